// ===== design/cbuf_defs.svh
// Constants for the circular-buffer address generator: register map,
// control bit positions, reset values and AXI4-Lite response codes.
// Assumes a 12-bit byte address on the register bus.
`ifndef CBUF_DEFS_SVH
`define CBUF_DEFS_SVH
`define OFS_IDX      12'h000
`define OFS_MOD      12'h040
`define OFS_BASE     12'h080
`define OFS_LEN      12'h0C0
`define OFS_CTRL     12'h100
`define OFS_PMASK    12'h104
`define OFS_STKY     12'h108
`define OFS_IMASK    12'h10C
`define CTRL_CBUF    0
`define CTRL_SIMD    1
`define PMASK_CBUF   0
`define STKY_G0      0
`define STKY_G1      1
`define IRQ_IDX_G0   4'h7
`define IRQ_IDX_G1   4'hF
`define ZERO32       32'h0000_0000
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// ===== design/cbuf_pkg.sv
// Types shared by the address generator and its surroundings.
// Assumes the decoder presents one operation per cycle.
package cbuf_pkg;
    typedef enum logic [2:0] {OP_NONE, OP_POST, OP_PRE, OP_MODIFY, OP_BITREV} op_kind_t;
    typedef enum logic {WR_IDLE, WR_RESP} wr_state_t;
    typedef enum logic {RD_IDLE, RD_DATA} rd_state_t;
    typedef struct packed {
        logic        valid;
        op_kind_t    kind;
        logic [3:0]  idx;
        logic [2:0]  msel;
        logic        use_imm;
        logic [31:0] imm;
        logic        long_word;
    } gen_op_t;
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        long_word;
        logic        simd;
    } bus_out_t;
endpackage

// ===== design/circular_buffer_address_gen.sv
// Two address generator units with index, step, base and length registers,
// circular post-modify, index adjust and bit-reverse adjust.
// Assumes operands from the decoder are valid for the cycle they are offered.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cbuf_defs.svh"

// Summary of operation
// - Post-modify access drives the old index on the bus, then adds the step.
// - Sum inside base..base+length is written back unchanged.
// - Positive overrun subtracts length; negative underrun adds length.
// - Post-modify and index adjust updates wrap; pre-modify never corrects addresses.
// - No detection of 32-bit address map overflow or underflow.
// - Enable clear makes post-modify a plain addition.
// - Status push or taken interrupt clears enable when mask bit set.
// - Base write also loads the same value into the index.
// - Index write leaves base alone; both read back separately.
// - Index adjust wraps when length nonzero, ignoring the enable bit.
// - Zero length disables wraparound for that index.
// - Step comes from any step register of same unit or immediate.
// - Index seven of each unit raises interrupt on wrap.
// - Long-word or SIMD access completes before wrap reaction.
// - Bit-reverse adjust adds immediate, reverses bits, writes back.
// - SIMD enable never changes the generated address.
// - Base accepts any value, no alignment limits.
// - Wrap of interrupting index sets sticky flag; interrupt is maskable.
module circular_buffer_address_gen import cbuf_pkg::*; (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [11:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [11:0] araddr,
    input  wire logic [2:0]  arprot,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    input  wire gen_op_t     op,
    input  wire logic        status_push_instruction,
    input  wire logic        irq_taken,
    output bus_out_t         bus_out,
    output logic             wrap_irq
);
    logic [31:0] idx_ff [16], nxt_idx [16];
    logic [31:0] mod_ff [16], nxt_mod [16];
    logic [31:0] base_ff [16], nxt_base [16];
    logic [31:0] len_ff [16], nxt_len [16];
    logic [31:0] primary_control_word_ff, nxt_primary_control_word;
    logic [31:0] status_push_mask_ff, nxt_status_push_mask;
    logic [31:0] sticky_status_word_ff, nxt_sticky_status_word;
    logic [31:0] irq_mask_ff, nxt_irq_mask;
    bus_out_t    bus_ff, nxt_bus;
    wr_state_t   wst_ff, nxt_wst;
    rd_state_t   rst_ff, nxt_rst;
    logic        irq_ff, nxt_irq, aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic [11:0] waddr_ff, nxt_waddr;
    logic [31:0] wdat_ff, nxt_wdat;
    logic [3:0]  wstb_ff, nxt_wstb;
    logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    // Circular update; the 32-bit sum wraps silently at the map edge
    function automatic logic [32:0] circ_step(input logic [31:0] i, input logic [31:0] m,
                                              input logic [31:0] b, input logic [31:0] l,
                                              input logic circ);
        logic [31:0] sum;
        logic [31:0] buf_end;
        logic [31:0] res;
        logic        wrap;
        sum     = i + m;
        buf_end = b + l;
        res     = sum;
        wrap    = 1'b0;
        if (circ && !m[31] && (sum >= buf_end)) begin
            res  = sum - l;
            wrap = 1'b1;
        end else if (circ && m[31] && (sum < b)) begin
            res  = sum + l;
            wrap = 1'b1;
        end
        return {wrap, res};
    endfunction
    // Bit order reversal for the bit-reverse adjust
    function automatic logic [31:0] rev32(input logic [31:0] v);
        logic [31:0] r;
        r = `ZERO32;
        for (int k = 0; k < 32; k++) begin
            r[k] = v[31-k];
        end
        return r;
    endfunction
    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                r[8*k +: 8] = nw[8*k +: 8];
            end
        end
        return r;
    endfunction
    // Register map decode shared by read and write paths; the four arrays sit below the control words
    function automatic logic is_array(input logic [11:0] a);
        return a < `OFS_CTRL;
    endfunction
    // Handshake outputs come straight from the state flops
    assign awready  = (wst_ff == WR_IDLE) && !aw_got_ff;
    assign wready   = (wst_ff == WR_IDLE) && !w_got_ff;
    assign bvalid   = (wst_ff == WR_RESP);
    assign bresp    = bresp_ff;
    assign arready  = (rst_ff == RD_IDLE);
    assign rvalid   = (rst_ff == RD_DATA);
    assign rdata    = rdata_ff;
    assign rresp    = rresp_ff;
    assign bus_out  = bus_ff;
    assign wrap_irq = irq_ff;
    // Next state of generator registers, control words and bus slave
    always_comb begin
        logic [32:0] upd;
        logic [3:0]  gi;
        logic [31:0] step;
        logic        circ;
        logic [11:0] a;
        logic        do_wr;
        upd  = 33'h0_0000_0000;
        gi   = op.idx;
        step = op.use_imm ? op.imm : mod_ff[{op.idx[3], op.msel}];
        circ = 1'b0;
        a    = 12'h000;
        nxt_idx  = idx_ff;
        nxt_mod  = mod_ff;
        nxt_base = base_ff;
        nxt_len  = len_ff;
        nxt_primary_control_word = primary_control_word_ff;
        nxt_status_push_mask     = status_push_mask_ff;
        nxt_sticky_status_word   = sticky_status_word_ff;
        nxt_irq_mask  = irq_mask_ff;
        nxt_bus       = '0;
        nxt_wst       = wst_ff;
        nxt_rst       = rst_ff;
        nxt_aw_got    = aw_got_ff;
        nxt_w_got     = w_got_ff;
        nxt_waddr     = waddr_ff;
        nxt_wdat      = wdat_ff;
        nxt_wstb      = wstb_ff;
        nxt_bresp     = bresp_ff;
        nxt_rresp     = rresp_ff;
        nxt_rdata     = rdata_ff;
        do_wr         = 1'b0;
        // Instruction path; SIMD flag only tags the data amount
        if (op.valid) begin
            case (op.kind)
                OP_POST: begin
                    nxt_bus.valid     = 1'b1;
                    nxt_bus.addr      = idx_ff[gi];
                    nxt_bus.long_word = op.long_word;
                    nxt_bus.simd      = primary_control_word_ff[`CTRL_SIMD];
                    circ = primary_control_word_ff[`CTRL_CBUF] && (len_ff[gi] != `ZERO32);
                    upd  = circ_step(idx_ff[gi], step, base_ff[gi], len_ff[gi], circ);
                    nxt_idx[gi] = upd[31:0];
                end
                OP_PRE: begin
                    nxt_bus.valid     = 1'b1;
                    nxt_bus.addr      = idx_ff[gi] + step;
                    nxt_bus.long_word = op.long_word;
                    nxt_bus.simd      = primary_control_word_ff[`CTRL_SIMD];
                end
                OP_MODIFY: begin
                    circ = (len_ff[gi] != `ZERO32);
                    upd  = circ_step(idx_ff[gi], step, base_ff[gi], len_ff[gi], circ);
                    nxt_idx[gi] = upd[31:0];
                end
                OP_BITREV: begin
                    nxt_idx[gi] = rev32(idx_ff[gi] + op.imm);
                end
                default: ;
            endcase
        end
        // Write channel: address and data in either order
        if (awvalid && awready) begin
            nxt_aw_got = 1'b1;
            nxt_waddr  = awaddr;
        end
        if (wvalid && wready) begin
            nxt_w_got = 1'b1;
            nxt_wdat  = wdata;
            nxt_wstb  = wstrb;
        end
        case (wst_ff)
            WR_IDLE: begin
                if (aw_got_ff && w_got_ff) begin
                    do_wr     = 1'b1;
                    nxt_wst   = WR_RESP;
                    nxt_bresp = `RESP_OKAY;
                end
            end
            WR_RESP: begin
                if (bready) begin
                    nxt_wst    = WR_IDLE;
                    nxt_aw_got = 1'b0;
                    nxt_w_got  = 1'b0;
                end
            end
            default: nxt_wst = WR_IDLE;
        endcase
        // Software write beats a same-cycle instruction update
        if (do_wr) begin
            a = waddr_ff;
            if (is_array(a)) begin
                case (a[7:6])
                    2'h0: nxt_idx[a[5:2]] = merge(idx_ff[a[5:2]], wdat_ff, wstb_ff);
                    2'h1: nxt_mod[a[5:2]] = merge(mod_ff[a[5:2]], wdat_ff, wstb_ff);
                    2'h2: begin
                        nxt_base[a[5:2]] = merge(base_ff[a[5:2]], wdat_ff, wstb_ff);
                        nxt_idx[a[5:2]]  = nxt_base[a[5:2]];
                    end
                    default: nxt_len[a[5:2]] = merge(len_ff[a[5:2]], wdat_ff, wstb_ff);
                endcase
            end else if (a == `OFS_CTRL) begin
                nxt_primary_control_word = merge(primary_control_word_ff, wdat_ff, wstb_ff);
            end else if (a == `OFS_PMASK) begin
                nxt_status_push_mask = merge(status_push_mask_ff, wdat_ff, wstb_ff);
            end else if (a == `OFS_STKY) begin
                nxt_sticky_status_word = sticky_status_word_ff & ~merge(`ZERO32, wdat_ff, wstb_ff);
            end else if (a == `OFS_IMASK) begin
                nxt_irq_mask = merge(irq_mask_ff, wdat_ff, wstb_ff);
            end else begin
                nxt_bresp = `RESP_SLVERR;
            end
        end
        // Automatic enable clear; wins over a same-cycle software set
        if ((status_push_instruction || irq_taken) && status_push_mask_ff[`PMASK_CBUF]) begin
            nxt_primary_control_word[`CTRL_CBUF] = 1'b0;
        end
        // Wrap flags OR-ed in after the software clear, so a set beats a same-cycle clear
        nxt_sticky_status_word[`STKY_G0] |= upd[32] && (gi == `IRQ_IDX_G0);
        nxt_sticky_status_word[`STKY_G1] |= upd[32] && (gi == `IRQ_IDX_G1);
        nxt_irq = |(sticky_status_word_ff & irq_mask_ff);
        // Read channel: data registered one cycle after address
        case (rst_ff)
            RD_IDLE: begin
                if (arvalid) begin
                    nxt_rst   = RD_DATA;
                    nxt_rresp = `RESP_OKAY;
                    nxt_rdata = `ZERO32;
                    if (is_array(araddr)) begin
                        case (araddr[7:6])
                            2'h0: nxt_rdata = idx_ff[araddr[5:2]];
                            2'h1: nxt_rdata = mod_ff[araddr[5:2]];
                            2'h2: nxt_rdata = base_ff[araddr[5:2]];
                            default: nxt_rdata = len_ff[araddr[5:2]];
                        endcase
                    end else if (araddr == `OFS_CTRL) begin
                        nxt_rdata = primary_control_word_ff;
                    end else if (araddr == `OFS_PMASK) begin
                        nxt_rdata = status_push_mask_ff;
                    end else if (araddr == `OFS_STKY) begin
                        nxt_rdata = sticky_status_word_ff;
                    end else if (araddr == `OFS_IMASK) begin
                        nxt_rdata = irq_mask_ff;
                    end else begin
                        nxt_rresp = `RESP_SLVERR;
                    end
                end
            end
            RD_DATA: nxt_rst = rready ? RD_IDLE : RD_DATA;
            default: nxt_rst = RD_IDLE;
        endcase
    end
    // Register stage; generator registers clear at reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < 16; k++) begin
                idx_ff[k]  <= `ZERO32;
                mod_ff[k]  <= `ZERO32;
                base_ff[k] <= `ZERO32;
                len_ff[k]  <= `ZERO32;
            end
            primary_control_word_ff <= `ZERO32;
            status_push_mask_ff     <= `ZERO32;
            sticky_status_word_ff   <= `ZERO32;
            irq_mask_ff <= `ZERO32;
            bus_ff      <= '0;
            irq_ff      <= 1'b0;
            wst_ff      <= WR_IDLE;
            rst_ff      <= RD_IDLE;
            aw_got_ff   <= 1'b0;
            w_got_ff    <= 1'b0;
            waddr_ff    <= 12'h000;
            wdat_ff     <= `ZERO32;
            wstb_ff     <= 4'h0;
            bresp_ff    <= `RESP_OKAY;
            rresp_ff    <= `RESP_OKAY;
            rdata_ff    <= `ZERO32;
        end else begin
            idx_ff  <= nxt_idx;
            mod_ff  <= nxt_mod;
            base_ff <= nxt_base;
            len_ff  <= nxt_len;
            primary_control_word_ff <= nxt_primary_control_word;
            status_push_mask_ff     <= nxt_status_push_mask;
            sticky_status_word_ff   <= nxt_sticky_status_word;
            irq_mask_ff <= nxt_irq_mask;
            bus_ff      <= nxt_bus;
            irq_ff      <= nxt_irq;
            wst_ff      <= nxt_wst;
            rst_ff      <= nxt_rst;
            aw_got_ff   <= nxt_aw_got;
            w_got_ff    <= nxt_w_got;
            waddr_ff    <= nxt_waddr;
            wdat_ff     <= nxt_wdat;
            wstb_ff     <= nxt_wstb;
            bresp_ff    <= nxt_bresp;
            rresp_ff    <= nxt_rresp;
            rdata_ff    <= nxt_rdata;
        end
    end
endmodule

// ===== dv/cbuf_checker_sva.sv
// Checker for the address generator: register-bus handshakes and op timing.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps
module cbuf_checker import cbuf_pkg::*; (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire gen_op_t     op,
    input wire bus_out_t    bus_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Steps of an access and of the two bus transfers
    sequence s_access;  op.valid && (op.kind == OP_POST || op.kind == OP_PRE); endsequence
    sequence s_wr_both; awvalid && awready && wvalid && wready; endsequence
    sequence s_rd_take; arvalid && arready; endsequence
    sequence s_no_access; !(op.valid && (op.kind == OP_POST || op.kind == OP_PRE)); endsequence
    access_drives_bus_a: assert property (s_access |=> bus_out.valid)
        else $error("access gave no bus cycle");
    adjust_no_bus_a: assert property (s_no_access |=> !bus_out.valid)
        else $error("bus cycle without access");
    long_word_kept_a: assert property (s_access |=> bus_out.long_word == $past(op.long_word))
        else $error("long-word tag lost on the bus");
    write_answer_a: assert property (s_wr_both |-> ##[1:2] bvalid)
        else $error("write response missing");
    read_answer_a: assert property (s_rd_take |=> rvalid)
        else $error("read response missing");
    read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    write_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    read_block_a: assert property (rvalid |-> !arready)
        else $error("read taken while answering");
    write_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answering");
endmodule

bind circular_buffer_address_gen cbuf_checker i_chk (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .op(op), .bus_out(bus_out));

// ===== dv/decoder_model.sv
// Decoder-side partner: offers one decoded op and catches the bus answer.
// Assumes issue is called right after a rising clock edge.
`timescale 1ns/1ps
module decoder_model import cbuf_pkg::*; (
    input  wire logic     aclk,
    output gen_op_t       op,
    input  wire bus_out_t bus_out
);
    gen_op_t nxt_op;
    initial op = '0;
    // Idle operands are scrambled so the design cannot lean on stale fields
    task automatic issue(input op_kind_t k, input logic [3:0] x, input logic [2:0] ms,
                         input logic ui, input logic [31:0] imm, output bus_out_t got);
        nxt_op = '{1'b1, k, x, ms, ui, imm, 1'($urandom_range(1))};
        op <= nxt_op;
        @(posedge aclk);
        nxt_op = ~nxt_op;
        nxt_op.valid = 1'b0;
        op <= nxt_op;
        @(posedge aclk);
        got = bus_out;
    endtask
endmodule

// ===== dv/circular_buffer_address_gen_tb.sv
// Self-checking bench for the address generator: registers over AXI4-Lite,
// ops through the decoder model. Assumes the design map in cbuf_defs.svh.
`timescale 1ns/1ps
`include "cbuf_defs.svh"
module circular_buffer_address_gen_tb import cbuf_pkg::*; ;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, push, irq_taken;
    logic        awready, wready, bvalid, arready, rvalid, wrap_irq, ui;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, b, l, m, i, im, st;
    logic [1:0]  bresp, rresp, ctl;
    logic [3:0]  x;
    logic [2:0]  ms;
    gen_op_t     op;
    bus_out_t    got;
    bus_out_t    bus_out;
    op_kind_t    k;
    int          miscompares, checks_done;

    circular_buffer_address_gen i_circular_buffer_address_gen (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .op(op),
        .status_push_instruction(push), .irq_taken(irq_taken), .bus_out(bus_out),
        .wrap_irq(wrap_irq));
    decoder_model i_decoder_model (.aclk(aclk), .op(op), .bus_out(bus_out));

    // Expected index after an update, same equations as the buffer rules
    function automatic logic [31:0] nxt_idx(input logic [31:0] i0, s, b0, l0, input logic c);
        logic [31:0] r;
        r = i0 + s;
        if (c && l0 != 32'h0) begin
            if (!s[31] && r >= b0 + l0) r = r - l0;
            else if (s[31] && r < b0) r = r + l0;
        end
        return r;
    endfunction
    function automatic logic [31:0] rev(input logic [31:0] v);
        for (int j = 0; j < 32; j++) rev[j] = v[31-j];
    endfunction
    task automatic chk32(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chkr(input logic [1:0] g, e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t response %h expected %h", $time, g, e);
        end
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
        logic aw, w;
        aw = 1;
        w = 1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready) begin
                aw = 0;
                awvalid <= 0;
            end
            if (w && wready) begin
                w = 0;
                wvalid <= 0;
            end
        end
        repeat ($urandom_range(2)) @(posedge aclk);
        bready <= 1;
        do @(posedge aclk); while (!bvalid);
        bready <= 0;
        chkr(bresp, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
        araddr <= a;
        arvalid <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        repeat ($urandom_range(2)) @(posedge aclk);
        rready <= 1;
        do @(posedge aclk); while (!rvalid);
        rready <= 0;
        chkr(rresp, e);
        chk32(rdata, v);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Free-running core clock
    initial begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end
    // Hang guard, well above the few thousand cycles the tests need
    initial begin
        repeat (90000) @(posedge aclk);
        miscompares++;
        close_out;
    end
    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, push, irq_taken} = 8'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        void'($urandom(46));
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(`OFS_CTRL, `ZERO32, `RESP_OKAY);
        rd(`OFS_IDX, `ZERO32, `RESP_OKAY);
        wr(12'h1F0, 32'h5A5A_5A5A, `RESP_SLVERR);
        rd(12'h1F0, `ZERO32, `RESP_SLVERR);
        // Random buffers, steps and op mixes; step stays below a nonzero length
        for (int n = 0; n < 60; n++) begin
            x = 4'($urandom_range(15));
            ms = 3'($urandom_range(7));
            ui = 1'($urandom_range(1));
            ctl = 2'($urandom_range(3));
            b = {1'b0, 31'($urandom)};
            l = ($urandom_range(7) == 0) ? 32'h0 : 32'($urandom_range(1, 4095));
            m = (l == 32'h0) ? 32'($urandom_range(255)) : 32'($urandom_range(l - 1));
            if ($urandom_range(1)) m = -m;
            im = ui ? m : $urandom;
            wr(`OFS_CTRL, {30'h0, ctl}, `RESP_OKAY);
            wr(`OFS_BASE + {6'h0, x, 2'h0}, b, `RESP_OKAY);
            rd(`OFS_IDX + {6'h0, x, 2'h0}, b, `RESP_OKAY);
            i = b + (l >> 1);
            wr(`OFS_IDX + {6'h0, x, 2'h0}, i, `RESP_OKAY);
            rd(`OFS_BASE + {6'h0, x, 2'h0}, b, `RESP_OKAY);
            wr(`OFS_LEN + {6'h0, x, 2'h0}, l, `RESP_OKAY);
            wr(`OFS_MOD + {6'h0, x[3], ms, 2'h0}, m, `RESP_OKAY);
            repeat (4) begin
                k = op_kind_t'(3'($urandom_range(1, 4)));
                st = (ui || k == OP_BITREV) ? im : m;
                i_decoder_model.issue(k, x, ms, ui, im, got);
                case (k)
                    OP_POST: begin
                        chk32(got.addr, i);
                        chk32({31'h0, got.simd}, {31'h0, ctl[1]});
                        i = nxt_idx(i, st, b, l, ctl[0]);
                    end
                    OP_PRE: chk32(got.addr, i + st);
                    OP_MODIFY: i = nxt_idx(i, st, b, l, 1'b1);
                    default: i = rev(i + st);
                endcase
            end
            rd(`OFS_IDX + {6'h0, x, 2'h0}, i, `RESP_OKAY);
        end
        // Wrap on the interrupting index of each unit
        for (int g = 0; g < 2; g++) begin
            x = g ? `IRQ_IDX_G1 : `IRQ_IDX_G0;
            wr(`OFS_STKY, 32'h3, `RESP_OKAY);
            wr(`OFS_IMASK, 32'h3, `RESP_OKAY);
            wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
            wr(`OFS_BASE + {6'h0, x, 2'h0}, 32'h100, `RESP_OKAY);
            wr(`OFS_LEN + {6'h0, x, 2'h0}, 32'h10, `RESP_OKAY);
            wr(`OFS_IDX + {6'h0, x, 2'h0}, 32'h10C, `RESP_OKAY);
            i_decoder_model.issue(OP_POST, x, 3'h0, 1'b1, 32'h8, got);
            rd(`OFS_IDX + {6'h0, x, 2'h0}, 32'h104, `RESP_OKAY);
            rd(`OFS_STKY, g ? 32'h2 : 32'h1, `RESP_OKAY);
            chk32({31'h0, wrap_irq}, 32'h1);
            wr(`OFS_IMASK, 32'h0, `RESP_OKAY);
            @(posedge aclk);
            chk32({31'h0, wrap_irq}, 32'h0);
            wr(`OFS_STKY, g ? 32'h2 : 32'h1, `RESP_OKAY);
            rd(`OFS_STKY, `ZERO32, `RESP_OKAY);
        end
        // Interrupting index as a plain pointer, interrupt unmasked: base zero and a long length keep it quiet
        x = `IRQ_IDX_G0;
        wr(`OFS_IMASK, 32'h3, `RESP_OKAY);
        wr(`OFS_BASE + {6'h0, x, 2'h0}, `ZERO32, `RESP_OKAY);
        wr(`OFS_LEN + {6'h0, x, 2'h0}, 32'hFFFF, `RESP_OKAY);
        wr(`OFS_IDX + {6'h0, x, 2'h0}, 32'h1000, `RESP_OKAY);
        i_decoder_model.issue(OP_MODIFY, x, 3'h0, 1'b1, 32'h1000, got);
        rd(`OFS_IDX + {6'h0, x, 2'h0}, 32'h2000, `RESP_OKAY);
        rd(`OFS_STKY, `ZERO32, `RESP_OKAY);
        chk32({31'h0, wrap_irq}, `ZERO32);
        wr(`OFS_IMASK, `ZERO32, `RESP_OKAY);
        // Enable clears on status push or interrupt only when masked in
        for (int e = 0; e < 3; e++) begin
            wr(`OFS_PMASK, (e < 2) ? 32'h1 : 32'h0, `RESP_OKAY);
            wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
            if (e == 1) irq_taken <= 1;
            else push <= 1;
            @(posedge aclk);
            push <= 0;
            irq_taken <= 0;
            rd(`OFS_CTRL, (e < 2) ? 32'h0 : 32'h1, `RESP_OKAY);
        end
        close_out;
    end
endmodule
